//--- include/lcd_seg_pkg.sv
package lcd_seg_pkg;
  // Geometry
  localparam int NUM_SEG = 32;
  localparam int NUM_PHASE = 4;
  localparam int NUM_LATCH = 128;
  localparam int LOC_W = 6;
  localparam int SEL_W = 7;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  // Register indices, byte address is four times the index
  localparam logic [7:0] IDX_WIN_LOW = 8'h44;
  localparam logic [7:0] IDX_WIN_MID = 8'h45;
  localparam logic [7:0] IDX_WIN_HIGH = 8'h46;
  localparam logic [7:0] IDX_POINTER = 8'h70;
  localparam logic [7:0] IDX_CTRL_A = 8'h71;
  localparam logic [7:0] IDX_CTRL_B = 8'h72;
  localparam logic [7:0] IDX_MAP_SEL = 8'h73;
  localparam logic [7:0] IDX_MAP_DATA = 8'h74;
  // Window bases within the location space
  localparam logic [1:0] WIN_BASE_LOW = 2'h0;
  localparam logic [1:0] WIN_BASE_MID = 2'h1;
  localparam logic [1:0] WIN_BASE_HIGH = 2'h2;
  // Control A fields
  localparam int CA_PULSE_LO = 2;
  localparam int CA_BOOST_LO = 0;
  // Control B fields
  localparam int CB_BLANK = 3;
  localparam int CB_POWER_DOWN = 2;
  localparam int CB_FOUR_WAY = 1;
  localparam int CB_EXT_BIAS = 0;
  // Reset values
  localparam logic [1:0] BOOST_RST = 2'h0;
  localparam logic [1:0] PULSE_RST = 2'h0;
  localparam logic BLANK_RST = 1'b1;
  localparam logic POWER_DOWN_RST = 1'b1;
  localparam logic FOUR_WAY_RST = 1'b1;
  localparam logic EXT_BIAS_RST = 1'b0;
  localparam logic [3:0] POINTER_RST = 4'h0;
  localparam logic [6:0] MAP_SEL_RST = 7'h00;
  // Timing: 32 kHz base derived from the system clock
  localparam int CLOCK_HZ = 100_000_000;
  localparam int BASE_HZ = 32768;
  localparam int TICK_CYCLES = CLOCK_HZ / BASE_HZ;
  localparam int PRESCALE_W = 15;
  localparam int TAP_CK10 = 5;
  localparam int TAP_MUX = 6;
  localparam int MUX_HZ = 256;
  typedef enum logic [1:0] {
    PHASE_ONE = 2'b00,
    PHASE_TWO = 2'b01,
    PHASE_THREE = 2'b10,
    PHASE_FOUR = 2'b11
  } phase_t;
endpackage

//--- design/lcd_timebase.sv
`timescale 1ns/1ns
module lcd_timebase #(
  parameter int TICK_DIV = lcd_seg_pkg::TICK_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic four_way_ratio,
  input wire logic [1:0] booster_clock_choice,
  output logic booster_tap,
  output lcd_seg_pkg::phase_t phase,
  output logic polarity
);
  import lcd_seg_pkg::*;

  logic [11:0] div_cnt;
  logic [PRESCALE_W-1:0] prescale;
  logic base_tick;
  logic mux_step;
  logic last_phase;
  phase_t next_phase;

  // Base tick and 256 Hz step on the rising edge of the mux tap
  assign base_tick = div_cnt == 12'(TICK_DIV - 1);
  assign mux_step = base_tick && (prescale[TAP_MUX:0] == 7'h3F);
  assign last_phase = four_way_ratio ? (phase == PHASE_FOUR)
                                     : (phase >= PHASE_THREE);
  assign next_phase = last_phase ? PHASE_ONE : phase_t'(phase + 2'h1);

  // Divider down to 32 kHz, then the prescaler chain
  always_ff @(posedge clock) begin
    if (!resetn) begin
      div_cnt <= 12'h000;
      prescale <= 15'h0000;
    end else if (base_tick) begin
      div_cnt <= 12'h000;
      prescale <= prescale + 15'h0001;
    end else begin
      div_cnt <= div_cnt + 12'h001;
    end
  end

  // Code 00 picks tap ten, each step up halves the rate
  always_ff @(posedge clock) begin
    if (!resetn) begin
      booster_tap <= 1'b0;
    end else begin
      booster_tap <= prescale[TAP_CK10 + int'(booster_clock_choice)];
    end
  end

  // Two polarity halves per phase keep the glass free of DC
  always_ff @(posedge clock) begin
    if (!resetn) begin
      phase <= PHASE_ONE;
      polarity <= 1'b0;
    end else if (mux_step) begin
      polarity <= ~polarity;
      if (polarity) begin
        phase <= next_phase;
      end
    end
  end
endmodule

//--- design/lcd_segment_mux_control.sv
// Design decision made here: register access over APB.
`timescale 1ns/1ns
module lcd_segment_mux_control #(
  parameter int TICK_DIV = lcd_seg_pkg::TICK_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic power_on_resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [lcd_seg_pkg::ADDR_W-1:0] paddr,
  input wire logic [lcd_seg_pkg::DATA_W-1:0] pwdata,
  output logic [lcd_seg_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [lcd_seg_pkg::NUM_SEG-1:0] display_drive_line,
  output logic [lcd_seg_pkg::NUM_PHASE-1:0] backplane_line,
  output logic drive_polarity,
  output logic booster_clock,
  output logic multiplier_enable,
  output logic regulator_enable,
  output logic bias_hiz,
  output logic bias_pull_low,
  output logic [1:0] pulse_output_choice
);
  import lcd_seg_pkg::*;

  logic [1:0] booster_clock_choice;
  logic display_blanking;
  logic display_power_down;
  logic four_way_ratio;
  logic external_bias_select;
  logic [3:0] offset_pointer;
  logic [SEL_W-1:0] map_sel;
  logic [LOC_W-1:0] map_loc [NUM_LATCH];
  logic [1:0] map_bit [NUM_LATCH];
  logic seg_latch [NUM_LATCH];
  logic booster_tap;
  phase_t phase;
  logic polarity;
  logic [NUM_SEG-1:0] next_drive;
  logic [NUM_PHASE-1:0] next_backplane;

  // Address decode
  wire [7:0] reg_index = paddr[9:2];
  wire word_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  wire hit_low = word_ok && (reg_index == IDX_WIN_LOW);
  wire hit_mid = word_ok && (reg_index == IDX_WIN_MID);
  wire hit_high = word_ok && (reg_index == IDX_WIN_HIGH);
  wire hit_pointer = word_ok && (reg_index == IDX_POINTER);
  wire hit_ctrl_a = word_ok && (reg_index == IDX_CTRL_A);
  wire hit_ctrl_b = word_ok && (reg_index == IDX_CTRL_B);
  wire hit_map_sel = word_ok && (reg_index == IDX_MAP_SEL);
  wire hit_map_data = word_ok && (reg_index == IDX_MAP_DATA);
  wire hit_win = hit_low || hit_mid || hit_high;
  wire mapped = hit_win || hit_pointer || hit_ctrl_a || hit_ctrl_b ||
                hit_map_sel || hit_map_data;
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire wr = access && pwrite && mapped;

  // Window plus pointer gives the location; upper high slots hold nothing
  wire win_valid = hit_win && !(hit_high && offset_pointer[3]);
  wire [1:0] win_base = hit_low ? WIN_BASE_LOW
                      : hit_mid ? WIN_BASE_MID : WIN_BASE_HIGH;
  wire [LOC_W-1:0] win_loc = {win_base, offset_pointer};
  wire win_wr = wr && win_valid;

  // Read nibble gathered from every latch mapped to the location
  wire [NUM_LATCH-1:0] rd_hit [NUM_PHASE];
  wire [3:0] win_nibble;
  wire [DATA_W-1:0] rd_value;

  genvar g;
  genvar b;
  generate
    for (g = 0; g < NUM_LATCH; g++) begin : g_latch
      for (b = 0; b < NUM_PHASE; b++) begin : g_bit
        assign rd_hit[b][g] = (map_loc[g] == win_loc) &&
                              (map_bit[g] == 2'(b)) && seg_latch[g];
      end
      // Latch storage has no reset on purpose, contents start undefined
      always_ff @(posedge clock) begin
        if (win_wr && (map_loc[g] == win_loc)) begin
          seg_latch[g] <= pwdata[map_bit[g]];
        end
      end
      // Allocation entry, default is one location per line, bit per phase
      always_ff @(posedge clock) begin
        if (!resetn || !power_on_resetn) begin
          map_loc[g] <= LOC_W'(g / NUM_PHASE);
          map_bit[g] <= 2'(g % NUM_PHASE);
        end else if (wr && hit_map_data && (map_sel == SEL_W'(g))) begin
          map_loc[g] <= pwdata[7:2];
          map_bit[g] <= pwdata[1:0];
        end
      end
    end
    for (b = 0; b < NUM_PHASE; b++) begin : g_nibble
      assign win_nibble[b] = win_valid && (|rd_hit[b]);
    end
  endgenerate

  // Read mux; unimplemented high slots read zero
  assign rd_value = hit_win ? {28'h0000000, win_nibble}
    : hit_pointer ? {28'h0000000, offset_pointer}
    : hit_ctrl_a ? {28'h0000000, pulse_output_choice, booster_clock_choice}
    : hit_ctrl_b ? {28'h0000000, display_blanking, display_power_down,
                    four_way_ratio, external_bias_select}
    : hit_map_sel ? {25'h0000000, map_sel}
    : hit_map_data ? {24'h000000, map_loc[map_sel], map_bit[map_sel]}
    : 32'h00000000;

  // Zero-wait slave: read data is caught during the setup cycle
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  always_ff @(posedge clock) begin
    if (!resetn || !power_on_resetn) begin
      prdata <= 32'h00000000;
    end else if (setup && !pwrite) begin
      prdata <= rd_value;
    end
  end

  // System-reset control bits
  always_ff @(posedge clock) begin
    if (!resetn || !power_on_resetn) begin
      booster_clock_choice <= BOOST_RST;
      display_blanking <= BLANK_RST;
      display_power_down <= POWER_DOWN_RST;
      four_way_ratio <= FOUR_WAY_RST;
      offset_pointer <= POINTER_RST;
      map_sel <= MAP_SEL_RST;
    end else begin
      if (wr && hit_ctrl_a) begin
        booster_clock_choice <= pwdata[CA_BOOST_LO +: 2];
      end
      if (wr && hit_ctrl_b) begin
        display_blanking <= pwdata[CB_BLANK];
        display_power_down <= pwdata[CB_POWER_DOWN];
        four_way_ratio <= pwdata[CB_FOUR_WAY];
      end
      if (wr && hit_pointer) begin
        offset_pointer <= pwdata[3:0];
      end
      if (wr && hit_map_sel) begin
        map_sel <= pwdata[SEL_W-1:0];
      end
    end
  end

  // Power-on only bits survive watchdog and pin resets
  always_ff @(posedge clock) begin
    if (!power_on_resetn) begin
      pulse_output_choice <= PULSE_RST;
      external_bias_select <= EXT_BIAS_RST;
    end else begin
      if (wr && hit_ctrl_a) begin
        pulse_output_choice <= pwdata[CA_PULSE_LO +: 2];
      end
      if (wr && hit_ctrl_b) begin
        external_bias_select <= pwdata[CB_EXT_BIAS];
      end
    end
  end

  lcd_timebase #(
    .TICK_DIV(TICK_DIV)
  ) u_timebase (
    .clock(clock),
    .resetn(resetn),
    .four_way_ratio(four_way_ratio),
    .booster_clock_choice(booster_clock_choice),
    .booster_tap(booster_tap),
    .phase(phase),
    .polarity(polarity)
  );

  // Segment selection per phase; latch four unreachable in three-way
  generate
    for (g = 0; g < NUM_SEG; g++) begin : g_seg
      assign next_drive[g] = !display_blanking && !display_power_down &&
        seg_latch[g * NUM_PHASE + int'(phase)];
    end
  endgenerate
  assign next_backplane = display_power_down ? 4'h0
    : (4'h1 << phase) & {four_way_ratio, 3'h7};

  // Analog stage enables
  assign multiplier_enable = !display_power_down &&
                             !external_bias_select;
  assign regulator_enable = multiplier_enable;
  assign bias_hiz = external_bias_select;
  assign bias_pull_low = display_power_down &&
                         !external_bias_select;

  // Registered pin drive
  always_ff @(posedge clock) begin
    if (!resetn || !power_on_resetn) begin
      display_drive_line <= 32'h00000000;
      backplane_line <= 4'h0;
      drive_polarity <= 1'b0;
      booster_clock <= 1'b0;
    end else begin
      display_drive_line <= next_drive;
      backplane_line <= next_backplane;
      drive_polarity <= polarity;
      booster_clock <= booster_tap && multiplier_enable;
    end
  end

  // Helpers for the checks below
  wire probe_bit = pwdata[map_bit[0]];
  wire probe_hit = win_wr && (map_loc[0] == win_loc);
  wire seg0_now = seg_latch[int'(phase)];

  AST_BACKPLANE_PHASE: assert property (
    @(posedge clock) disable iff (!resetn || !power_on_resetn)
    !display_power_down && four_way_ratio |=>
      backplane_line == (4'h1 << $past(phase)))
    else $error("backplane not matching phase");

  AST_LATCH_PHASE: assert property (
    @(posedge clock) disable iff (!resetn || !power_on_resetn)
    !display_blanking && !display_power_down |=>
      display_drive_line[0] == $past(seg0_now))
    else $error("drive line not showing latch of phase");

  AST_THREE_WAY_SKIP: assert property (
    @(posedge clock) disable iff (!resetn || !power_on_resetn)
    !four_way_ratio && $stable(four_way_ratio) && $changed(phase) |->
      phase != PHASE_FOUR)
    else $error("phase four entered in three-way ratio");

  AST_BP4_OFF: assert property (
    @(posedge clock) disable iff (!resetn || !power_on_resetn)
    !four_way_ratio |=> !backplane_line[3])
    else $error("backplane four active in three-way ratio");

  AST_BLANK: assert property (
    @(posedge clock) disable iff (!resetn || !power_on_resetn)
    display_blanking |=> display_drive_line == 32'h00000000)
    else $error("drive lines active while blanked");

  AST_POWER_DOWN: assert property (
    @(posedge clock) disable iff (!resetn || !power_on_resetn)
    display_power_down |-> !multiplier_enable ##1
      (backplane_line == 4'h0 && !booster_clock))
    else $error("display active while powered down");

  AST_EXT_BIAS: assert property (
    @(posedge clock) disable iff (!power_on_resetn)
    external_bias_select |-> bias_hiz && !regulator_enable &&
      !multiplier_enable && !bias_pull_low)
    else $error("external bias not isolating internal supply");

  AST_PULL_LOW: assert property (
    @(posedge clock) disable iff (!power_on_resetn)
    display_power_down && !external_bias_select |-> bias_pull_low)
    else $error("bias outputs not pulled low when off");

  AST_POR_ONLY: assert property (
    @(posedge clock) disable iff (!power_on_resetn)
    !resetn |=> external_bias_select == $past(external_bias_select) &&
      pulse_output_choice == $past(pulse_output_choice))
    else $error("power-on bits changed by system reset");

  AST_RESET_VALUES: assert property (
    @(posedge clock)
    !resetn ##1 resetn |-> booster_clock_choice == 2'h0 &&
      display_blanking && display_power_down && four_way_ratio &&
      map_loc[5] == 6'h01 && map_bit[5] == 2'h1)
    else $error("reset values wrong");

  AST_MAPPED_WRITE: assert property (
    @(posedge clock) disable iff (!resetn || !power_on_resetn)
    probe_hit |=> seg_latch[0] == $past(probe_bit))
    else $error("latch did not take its mapped bus bit");

  AST_HIGH_EMPTY: assert property (
    @(posedge clock) disable iff (!resetn || !power_on_resetn)
    setup && !pwrite && hit_high && offset_pointer[3] |=>
      prdata == 32'h00000000 && !pslverr)
    else $error("unimplemented high slot returned data");

  AST_PHASE_STEP: assert property (
    @(posedge clock) disable iff (!resetn)
    $changed(phase) |-> phase == PHASE_ONE ||
      phase == phase_t'($past(phase) + 2'h1))
    else $error("phase sequence skipped");

  COV_THREE_WAY_WRAP: cover property (
    @(posedge clock) disable iff (!resetn)
    !four_way_ratio && $past(phase) == PHASE_THREE && phase == PHASE_ONE);
  COV_FOUR_WAY_WRAP: cover property (
    @(posedge clock) disable iff (!resetn)
    $past(phase) == PHASE_FOUR && phase == PHASE_ONE);
  COV_WINDOW_WRITE: cover property (
    @(posedge clock) disable iff (!resetn) win_wr && hit_high);
  COV_EXT_BIAS: cover property (
    @(posedge clock) disable iff (!power_on_resetn) $rose(bias_hiz));
endmodule

//--- tb/lcd_glass_model.sv
`timescale 1ns/1ns
module lcd_glass_model (
  input wire logic clock,
  input wire logic clear,
  input wire logic [3:0] backplane_line,
  input wire logic [31:0] display_drive_line,
  output logic [31:0] seen [4],
  output int hits [4],
  output int run_len,
  output logic overlap
);
  logic [3:0] last_bp;
  int run;
  // Glass lights a segment only under its own active backplane
  always @(posedge clock) begin
    if (clear) begin
      for (int p = 0; p < 4; p++) begin
        hits[p] <= 0;
      end
      overlap <= 1'b0;
      run <= 0;
      run_len <= 0;
    end else begin
      if ($countones(backplane_line) > 1) begin
        overlap <= 1'b1;
      end
      for (int p = 0; p < 4; p++) begin
        if (backplane_line[p]) begin
          seen[p] <= display_drive_line;
          hits[p] <= hits[p] + 1;
        end
      end
      // Length of the finished backplane state, partial runs included
      if (backplane_line != last_bp) begin
        run_len <= run;
        run <= 1;
      end else begin
        run <= run + 1;
      end
    end
    last_bp <= backplane_line;
  end
endmodule

//--- tb/lcd_segment_mux_control_bench.sv
`timescale 1ns/1ns
module lcd_segment_mux_control_bench;
  import lcd_seg_pkg::*;
  localparam int TDIV = 4;
  typedef struct packed {
    logic [7:0] idx;
    logic [31:0] wd;
    logic [31:0] ex;
    logic er;
  } row_t;
  logic clock, resetn, power_on_resetn, psel, penable, pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rdat;
  logic pready, pslverr, rerr, clear;
  logic [NUM_SEG-1:0] display_drive_line;
  logic [NUM_PHASE-1:0] backplane_line;
  logic booster_clock, multiplier_enable, regulator_enable;
  logic bias_hiz, bias_pull_low, overlap, pol, pol_was;
  logic [1:0] pulse_output_choice;
  logic [31:0] seen [4];
  int hits [4];
  int run_len, mismatches, samples_checked, per;
  row_t rows [6] = '{
    '{8'h70, 32'h5, 32'h5, 1'b0}, '{8'h71, 32'hF, 32'hF, 1'b0},
    // Control B row stays blanked: latches hold nothing yet
    '{8'h71, 32'h0, 32'h0, 1'b0}, '{8'h72, 32'hA, 32'hA, 1'b0},
    '{8'h50, 32'h1, 32'h0, 1'b1}, '{8'h47, 32'h1, 32'h0, 1'b1}};

  lcd_segment_mux_control #(.TICK_DIV(TDIV)) dut (
    .clock(clock), .resetn(resetn), .power_on_resetn(power_on_resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .display_drive_line(display_drive_line),
    .backplane_line(backplane_line), .drive_polarity(pol),
    .booster_clock(booster_clock), .multiplier_enable(multiplier_enable),
    .regulator_enable(regulator_enable), .bias_hiz(bias_hiz),
    .bias_pull_low(bias_pull_low),
    .pulse_output_choice(pulse_output_choice));

  lcd_glass_model glass (
    .clock(clock), .clear(clear), .backplane_line(backplane_line),
    .display_drive_line(display_drive_line), .seen(seen), .hits(hits),
    .run_len(run_len), .overlap(overlap));

  // Free-running 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One edge of idle first, so psel is never assigned twice in a step
  task automatic apb(input logic [7:0] idx, input logic wr,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clock);
    end
    if (n >= 50) begin
      mismatches++;
      $display("[ERR] %0t no pready", $time);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
    apb(idx, 1'b0, 32'h0);
    check(rdat, exp, "read");
  endtask

  task automatic win(input int loc, input logic [3:0] d);
    apb(IDX_POINTER, 1'b1, 32'(loc % 16));
    apb(8'(8'h44 + loc / 16), 1'b1, 32'(d));
  endtask

  function automatic logic [3:0] pat(int i);
    return 4'(i * 7 + 3);
  endfunction

  function automatic logic [31:0] expv(int p);
    logic [31:0] v;
    logic [3:0] t;
    for (int i = 0; i < 32; i++) begin
      t = pat(i);
      v[i] = t[p];
    end
    return v;
  endfunction

  // Booster period in clocks, between two rising edges
  task automatic period(output int n);
    int k, rises;
    logic prev;
    k = 0;
    rises = 0;
    n = 0;
    prev = booster_clock;
    while (rises < 2 && k < 20000) begin
      @(posedge clock);
      k++;
      if (rises == 1) n++;
      if (booster_clock && !prev) rises++;
      prev = booster_clock;
    end
  endtask

  task automatic resets(input logic por);
    resetn <= por;
    power_on_resetn <= ~por;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    power_on_resetn <= 1'b1;
  endtask

  // Hang guard, well beyond the expected run
  initial begin
    #1_000_000;
    $display("[ERR] %0t watchdog expired", $time);
    mismatches++;
    test_done();
  end

  initial begin
    {resetn, power_on_resetn, psel, penable, pwrite, clear} = '0;
    paddr = '0;
    pwdata = '0;
    mismatches = 0;
    samples_checked = 0;
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    power_on_resetn <= 1'b1;
    rchk(IDX_CTRL_A, 32'h0);
    rchk(IDX_CTRL_B, 32'hE);
    check(multiplier_enable, 1'b0, "mult");
    check(bias_pull_low, 1'b1, "pull");
    // Plain register rows, unmapped places among them
    foreach (rows[r]) begin
      apb(rows[r].idx, 1'b1, rows[r].wd);
      check(rerr, rows[r].er, "werr");
      rchk(rows[r].idx, rows[r].ex);
      check(rerr, rows[r].er, "rerr");
    end
    // Default allocation: line i at location i, bit p to phase p
    for (int i = 0; i < 32; i++) win(i, pat(i));
    // Unblank only once every latch holds a known value
    apb(IDX_CTRL_B, 1'b1, 32'h2);
    apb(IDX_POINTER, 1'b1, 32'h3);
    rchk(IDX_WIN_MID, 32'(pat(19)));
    clear <= 1'b1;
    @(posedge clock);
    clear <= 1'b0;
    repeat (5200) @(posedge clock);
    for (int p = 0; p < 4; p++) check(seen[p], expv(p), "phase");
    check(overlap, 1'b0, "onehot");
    check(run_len, 2 * 128 * TDIV, "len");
    // Polarity flips once per 256 Hz step, whatever the start point
    pol_was = pol;
    repeat (128 * TDIV) @(posedge clock);
    check(pol ^ pol_was, 1'b1, "polarity");
    // Remap latch 0 to location 39 bit 3, empty upper high window
    apb(IDX_MAP_SEL, 1'b1, 32'h0);
    apb(IDX_MAP_DATA, 1'b1, 32'h9F);
    rchk(IDX_MAP_DATA, 32'h9F);
    win(39, 4'h8);
    rchk(IDX_WIN_HIGH, 32'h8);
    win(40, 4'hF);
    check(rerr, 1'b0, "herr");
    rchk(IDX_WIN_HIGH, 32'h0);
    // Three-way ratio
    apb(IDX_CTRL_B, 1'b1, 32'h0);
    clear <= 1'b1;
    @(posedge clock);
    clear <= 1'b0;
    repeat (6300) @(posedge clock);
    check(hits[3], 0, "ph4");
    check(seen[0][0], 1'b1, "remap");
    check(seen[2], expv(2), "ph3");
    check(run_len, 2 * 128 * TDIV, "len3");
    // Blank keeps backplanes, power down stops backplanes and supplies and pulls bias low
    apb(IDX_CTRL_B, 1'b1, 32'hA);
    repeat (3) @(posedge clock);
    check(display_drive_line, 32'h0, "blank");
    check(backplane_line == 4'h0, 1'b0, "bpblank");
    apb(IDX_CTRL_B, 1'b1, 32'h6);
    repeat (3) @(posedge clock);
    check({backplane_line, multiplier_enable, regulator_enable,
           bias_pull_low, bias_hiz}, 8'h02, "off");
    apb(IDX_POINTER, 1'b1, 32'h5);
    rchk(IDX_WIN_LOW, 32'(pat(5)));
    apb(IDX_CTRL_B, 1'b1, 32'h3);
    @(posedge clock);
    check({multiplier_enable, regulator_enable, bias_pull_low, bias_hiz},
          4'h1, "ext");
    // Booster taps: code c gives 64 << c base ticks
    apb(IDX_CTRL_B, 1'b1, 32'h2);
    for (int c = 0; c < 4; c++) begin
      apb(IDX_CTRL_A, 1'b1, 32'(c));
      period(per);
      period(per);
      check(per, (64 << c) * TDIV, "boost");
    end
    // System reset spares the power-on-only bits
    apb(IDX_CTRL_A, 1'b1, 32'hC);
    apb(IDX_CTRL_B, 1'b1, 32'h1);
    resets(1'b0);
    rchk(IDX_CTRL_A, 32'hC);
    check(pulse_output_choice, 2'h3, "pulse");
    rchk(IDX_CTRL_B, 32'hF);
    resets(1'b1);
    rchk(IDX_CTRL_A, 32'h0);
    rchk(IDX_CTRL_B, 32'hE);
    test_done();
  end
endmodule
